// File: osc_model.sv
`timescale 1ns/10ps
// ****************************************
// crystal oscillator stand-in
// ****************************************
module osc_model
#(
	parameter int HALF_NS = 16
)
(
	input  wire logic run,
	output logic      osc_clk
);
	// idle level low while stopped
	initial osc_clk = 1'b0;
	// whole periods only, so a stop never leaves a runt pulse
	always
	begin
		wait (run);
		#HALF_NS osc_clk = 1'b1;
		#HALF_NS osc_clk = 1'b0;
	end
endmodule

// File: osc_sync.sv
`timescale 1ns/10ps
module osc_sync
	import rtc_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// three-stage chain; only s2/s3 agreement is trusted
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// filtered level and its rising edge
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level_r <= 1'b0;
			rise    <= 1'b0;
		end
		else
		begin
			rise <= 1'b0;
			if (s2_r == s3_r)
			begin
				level_r <= s3_r;
				rise    <= s3_r & ~level_r;
			end
		end
	end
endmodule

// File: rtc_calendar_and_irq_flags_tb_top.sv
`timescale 1ns/10ps
module rtc_calendar_and_irq_flags_tb_top
	import rtc_pkg::*;
;
	// short second keeps the run small; ticks come every EPS edges
	localparam int EPS = 4;
	logic       clock               = 1'b0;
	logic       rst_n               = 1'b0;
	logic       osc_run             = 1'b0;
	logic       osc_clk;
	logic       power_on_flag       = 1'b0;
	logic       hour_mode_24        = 1'b1;
	logic       periodic_level_mode = 1'b1;
	logic       weekly_alarm_enable = 1'b0;
	logic       daily_alarm_enable  = 1'b0;
	logic       weekly_alarm_match  = 1'b0;
	logic       daily_alarm_match   = 1'b0;
	logic [3:0] reg_addr            = 4'h0;
	logic       reg_wr              = 1'b0;
	logic [7:0] reg_wdata           = 8'h00;
	logic [7:0] reg_rdata;
	logic       interrupt_out_n;
	int         errors              = 0;
	int         num_checks          = 0;

	// ****************************************
	// clock, oscillator and device
	// ****************************************
	always #2 clock = ~clock;

	osc_model i_osc (.run(osc_run), .osc_clk(osc_clk));

	rtc_core #(.EDGES_PER_SEC(EPS)) i_dut (
		.clock               (clock),
		.rst_n               (rst_n),
		.osc_clk             (osc_clk),
		.power_on_flag       (power_on_flag),
		.hour_mode_24        (hour_mode_24),
		.periodic_level_mode (periodic_level_mode),
		.weekly_alarm_enable (weekly_alarm_enable),
		.daily_alarm_enable  (daily_alarm_enable),
		.weekly_alarm_match  (weekly_alarm_match),
		.daily_alarm_match   (daily_alarm_match),
		.reg_addr            (reg_addr),
		.reg_wr              (reg_wr),
		.reg_wdata           (reg_wdata),
		.reg_rdata           (reg_rdata),
		.interrupt_out_n     (interrupt_out_n)
	);

	// ****************************************
	// access tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	// two extra edges of margin; read data is resampled every cycle anyway
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		repeat (3) @(posedge clock);
		#1;
		check(reg_rdata, exp);
	endtask

	task automatic pin(input logic exp);
		check({7'h00, interrupt_out_n}, {7'h00, exp});
	endtask

	// run whole oscillator periods, then let the synchroniser settle
	task automatic osc(input int n);
		@(posedge clock);
		osc_run <= 1'b1;
		repeat (n) @(posedge osc_clk);
		@(posedge clock);
		osc_run <= 1'b0;
		repeat (12) @(posedge clock);
	endtask

	// seconds last, so its divider clear starts the full second
	task automatic set_tod(input tod_t t);
		wr(YEAR_ADDR, t.year);
		wr(MON_ADDR, t.mon);
		wr(MDAY_ADDR, t.mday);
		wr(WDAY_ADDR, t.wday);
		wr(HOUR_ADDR, t.hour);
		wr(MIN_ADDR, t.min);
		wr(SEC_ADDR, t.sec);
	endtask

	task automatic rd_tod(input tod_t t);
		rd(SEC_ADDR, t.sec);
		rd(MIN_ADDR, t.min);
		rd(HOUR_ADDR, t.hour);
		rd(WDAY_ADDR, t.wday);
		rd(MDAY_ADDR, t.mday);
		rd(MON_ADDR, t.mon);
		rd(YEAR_ADDR, t.year);
	endtask

	// one second from a, expect b, then periodic flag set and cleared
	task automatic roll(input logic m, input tod_t a, input tod_t b);
		@(posedge clock);
		hour_mode_24 <= m;
		set_tod(a);
		osc(EPS);
		rd_tod(b);
		rd(FLAG_ADDR, 8'h04);
		pin(1'b0);
		wr(FLAG_ADDR, 8'h00);
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
	endtask

	task automatic match(input logic [1:0] m);
		@(posedge clock);
		weekly_alarm_match <= m[1];
		daily_alarm_match  <= m[0];
		@(posedge clock);
		weekly_alarm_match <= 1'b0;
		daily_alarm_match  <= 1'b0;
	endtask

	// seconds write first keeps the two edges short of a tick
	task automatic alarm(input logic [1:0] m);
		wr(SEC_ADDR, 8'h00);
		match(m);
		osc(2);
	endtask

	// ****************************************
	// watchdog: whole run is well under 60 us
	// ****************************************
	initial
	begin
		#300000;
		errors++;
		end_of_test();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd_tod(56'h00000000010100);
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
		wr(4'h7, 8'hFF);
		rd(4'h7, 8'h00);
		wr(FLAG_ADDR, 8'hFF);
		rd(FLAG_ADDR, 8'h00);
		set_tod(56'hD9D9E3F5F1F247);
		rd_tod(56'h59592305319247);
		// calendar and clock rollovers
		roll(1'b1, 56'h59592306311299, 56'h00000000018100);
		roll(1'b1, 56'h59592305319299, 56'h00000006010100);
		roll(1'b1, 56'h59592302280204, 56'h00000003290204);
		roll(1'b1, 56'h59592303280203, 56'h00000004010303);
		roll(1'b1, 56'h59592306290296, 56'h00000000010396);
		roll(1'b1, 56'h59592304300405, 56'h00000005010505);
		roll(1'b1, 56'h59120701150610, 56'h00130701150610);
		roll(1'b0, 56'h59593101100120, 56'h00001202110120);
		roll(1'b0, 56'h59591101100120, 56'h00003201100120);
		roll(1'b0, 56'h59592301100120, 56'h00002401100120);
		roll(1'b0, 56'h59591201100120, 56'h00000101100120);
		// seconds write restarts the divider
		wr(SEC_ADDR, 8'h30);
		osc(2);
		wr(SEC_ADDR, 8'h30);
		osc(EPS - 1);
		rd(SEC_ADDR, 8'h30);
		osc(1);
		rd(SEC_ADDR, 8'h31);
		@(posedge clock);
		periodic_level_mode <= 1'b0;
		wr(FLAG_ADDR, 8'h00);
		rd(FLAG_ADDR, 8'h04);
		@(posedge clock);
		periodic_level_mode <= 1'b1;
		wr(FLAG_ADDR, 8'hFF);
		rd(FLAG_ADDR, 8'h04);
		wr(FLAG_ADDR, 8'h00);
		// alarm flags: delay, clear, enable gating
		@(posedge clock);
		weekly_alarm_enable <= 1'b1;
		wr(SEC_ADDR, 8'h00);
		match(2'b10);
		osc(1);
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
		osc(1);
		rd(FLAG_ADDR, 8'h02);
		pin(1'b0);
		wr(FLAG_ADDR, 8'h03);
		rd(FLAG_ADDR, 8'h02);
		wr(FLAG_ADDR, 8'h00);
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
		alarm(2'b01);
		rd(FLAG_ADDR, 8'h00);
		@(posedge clock);
		daily_alarm_enable <= 1'b1;
		alarm(2'b01);
		rd(FLAG_ADDR, 8'h01);
		pin(1'b0);
		@(posedge clock);
		daily_alarm_enable <= 1'b0;
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
		// power-on clears flags, counters stay
		alarm(2'b10);
		rd(FLAG_ADDR, 8'h02);
		@(posedge clock);
		power_on_flag <= 1'b1;
		repeat (3) @(posedge clock);
		power_on_flag <= 1'b0;
		rd(FLAG_ADDR, 8'h00);
		pin(1'b1);
		rd(SEC_ADDR, 8'h00);
		end_of_test();
	end
endmodule

// File: rtc_core.sv
`timescale 1ns/10ps
module rtc_core
	import rtc_pkg::*;
#(
	parameter int EDGES_PER_SEC = OSC_HZ
)
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       osc_clk,
	input  wire logic       power_on_flag,
	input  wire logic       hour_mode_24,
	input  wire logic       periodic_level_mode,
	input  wire logic       weekly_alarm_enable,
	input  wire logic       daily_alarm_enable,
	input  wire logic       weekly_alarm_match,
	input  wire logic       daily_alarm_match,
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	output logic            interrupt_out_n
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction

	// tens*10+ones mod 4 equals (2*tens+ones) mod 4
	function automatic logic is_leap(input logic [7:0] y);
		logic [1:0] m;
		m = {y[4], 1'b0} + y[1:0];
		is_leap = (m == 2'h0);
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] mon,
		input logic [7:0] year);
		case (mon[4:0])
			5'h02:   last_day = is_leap(year) ? 8'h29 : 8'h28;
			5'h04,
			5'h06,
			5'h09,
			5'h11:   last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	// returns {day carry, next hour}
	function automatic logic [8:0] hour_step(input logic [7:0] h,
		input logic m24);
		logic [7:0] n;
		// 12-hour ones step works on bits 4..0 only, so pm bit survives
		n = bcd_inc({3'h0, h[4:0]});
		if (m24)
			hour_step = (h == 8'h23) ? {1'b1, 8'h00} : {1'b0, bcd_inc(h)};
		else if (h[4:0] == 5'h12)
			hour_step = {1'b0, h[7:5], 5'h01};
		else if (h[4:0] == 5'h11)
			hour_step = {h[PM_BIT], h[7:6], ~h[PM_BIT], 5'h12};
		else
			hour_step = {1'b0, h[7:5], n[4:0]};
	endfunction

	// ****************************************
	// oscillator sampling and divider
	// ****************************************
	logic osc_edge;
	logic sec_tick;
	logic wr_sec;

	assign wr_sec = reg_wr && reg_addr == SEC_ADDR;

	osc_sync u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (osc_clk),
		.rise     (osc_edge)
	);

	sec_divider #(.EDGES_PER_SEC(EDGES_PER_SEC)) u_div (
		.clock    (clock),
		.rst_n    (rst_n),
		.osc_edge (osc_edge),
		.clear    (wr_sec),
		.sec_tick (sec_tick)
	);

	// ****************************************
	// carry chain
	// ****************************************
	tod_t       tod_r;
	logic [8:0] hstep;
	logic       sec_c;
	logic       min_c;
	logic       day_c;
	logic       mon_c;
	logic       yr_c;
	logic       cen_c;

	assign hstep = hour_step(tod_r.hour, hour_mode_24);
	assign sec_c = sec_tick && tod_r.sec == 8'h59;
	assign min_c = sec_c && tod_r.min == 8'h59;
	assign day_c = min_c && hstep[8];
	assign mon_c = day_c && tod_r.mday == last_day(tod_r.mon, tod_r.year);
	assign yr_c  = mon_c && tod_r.mon[4:0] == 5'h12;
	assign cen_c = yr_c && tod_r.year == 8'h99;

	// ****************************************
	// time counters
	// ****************************************
	// a host write wins over a carry into the same counter;
	// invalid written values are the host's problem
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tod_r.sec  <= ZERO_RST;
			tod_r.min  <= ZERO_RST;
			tod_r.hour <= ZERO_RST;
		end
		else
		begin
			if (wr_sec)
				tod_r.sec <= reg_wdata & SEC_MASK;
			else if (sec_c)
				tod_r.sec <= ZERO_RST;
			else if (sec_tick)
				tod_r.sec <= bcd_inc(tod_r.sec);
			if (reg_wr && reg_addr == MIN_ADDR)
				tod_r.min <= reg_wdata & MIN_MASK;
			else if (min_c)
				tod_r.min <= ZERO_RST;
			else if (sec_c)
				tod_r.min <= bcd_inc(tod_r.min);
			if (reg_wr && reg_addr == HOUR_ADDR)
				tod_r.hour <= reg_wdata & HOUR_MASK;
			else if (min_c)
				tod_r.hour <= hstep[7:0];
		end
	end

	// ****************************************
	// calendar counters
	// ****************************************
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tod_r.wday <= ZERO_RST;
			tod_r.mday <= ONE_RST;
			tod_r.mon  <= ONE_RST;
			tod_r.year <= ZERO_RST;
		end
		else
		begin
			if (reg_wr && reg_addr == WDAY_ADDR)
				tod_r.wday <= reg_wdata & WDAY_MASK;
			else if (day_c)
				tod_r.wday <= (tod_r.wday[2:0] >= 3'h6) ? ZERO_RST :
					tod_r.wday + 8'h01;
			if (reg_wr && reg_addr == MDAY_ADDR)
				tod_r.mday <= reg_wdata & MDAY_MASK;
			else if (mon_c)
				tod_r.mday <= ONE_RST;
			else if (day_c)
				tod_r.mday <= bcd_inc(tod_r.mday);
			if (reg_wr && reg_addr == MON_ADDR)
				tod_r.mon <= reg_wdata & MON_MASK;
			else if (yr_c)
				tod_r.mon <= {tod_r.mon[CENTURY_BIT] ^ cen_c, 7'h01};
			else if (mon_c)
				tod_r.mon <= bcd_inc(tod_r.mon);
			if (reg_wr && reg_addr == YEAR_ADDR)
				tod_r.year <= reg_wdata & YEAR_MASK;
			else if (cen_c)
				tod_r.year <= ZERO_RST;
			else if (yr_c)
				tod_r.year <= bcd_inc(tod_r.year);
		end
	end

	// ****************************************
	// interrupt flags
	// ****************************************
	logic       wr_flag;
	logic       pirq_r;
	logic       walm_r;
	logic       dalm_r;
	logic [1:0] wcnt_r;
	logic [1:0] dcnt_r;
	localparam logic [1:0] DLY = 2'(ALARM_DELAY_EDGES);

	assign wr_flag = reg_wr && reg_addr == FLAG_ADDR;

	// periodic flag: set on the second tick in level mode, with the seconds increment;
	// the pin falls one clock later; set beats a same-cycle write clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pirq_r <= 1'b0;
		else if (power_on_flag)
			pirq_r <= 1'b0;
		else if (sec_tick && periodic_level_mode)
			pirq_r <= 1'b1;
		// write 0 clears in level mode
		else if (wr_flag && periodic_level_mode && !reg_wdata[PIRQ_BIT])
			pirq_r <= 1'b0;
	end

	// alarm delay: counts oscillator edges after the match
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wcnt_r <= 2'h0;
			dcnt_r <= 2'h0;
		end
		else
		begin
			if (weekly_alarm_match && weekly_alarm_enable)
				wcnt_r <= DLY;
			else if (osc_edge && wcnt_r != 2'h0)
				wcnt_r <= wcnt_r - 2'h1;
			if (daily_alarm_match && daily_alarm_enable)
				dcnt_r <= DLY;
			else if (osc_edge && dcnt_r != 2'h0)
				dcnt_r <= dcnt_r - 2'h1;
		end
	end

	// alarm flags; a disabled alarm holds its flag at zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			walm_r <= 1'b0;
			dalm_r <= 1'b0;
		end
		else
		begin
			if (power_on_flag || !weekly_alarm_enable)
				walm_r <= 1'b0;
			else if (osc_edge && wcnt_r == 2'h1)
				walm_r <= 1'b1;
			else if (wr_flag && !reg_wdata[WALM_BIT])
				walm_r <= 1'b0;
			if (power_on_flag || !daily_alarm_enable)
				dalm_r <= 1'b0;
			else if (osc_edge && dcnt_r == 2'h1)
				dalm_r <= 1'b1;
			else if (wr_flag && !reg_wdata[DALM_BIT])
				dalm_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			interrupt_out_n <= 1'b1;
		else
			interrupt_out_n <= ~(pirq_r | walm_r | dalm_r);
	end

	// ****************************************
	// read port
	// ****************************************
	// unused bits read zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			case (reg_addr)
				SEC_ADDR:  reg_rdata <= tod_r.sec;
				MIN_ADDR:  reg_rdata <= tod_r.min;
				HOUR_ADDR: reg_rdata <= tod_r.hour;
				WDAY_ADDR: reg_rdata <= tod_r.wday;
				MDAY_ADDR: reg_rdata <= tod_r.mday;
				MON_ADDR:  reg_rdata <= tod_r.mon;
				YEAR_ADDR: reg_rdata <= tod_r.year;
				FLAG_ADDR: reg_rdata <= {5'h00, pirq_r, walm_r, dalm_r};
				default:   reg_rdata <= 8'h00;
			endcase
	end

	// ****************************************
	// checks
	// ****************************************
	logic quiet;
	assign quiet = !reg_wr && !power_on_flag;

	chk_sec_wrap: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && tod_r.sec == 8'h59 && quiet
		|=> tod_r.sec == 8'h00 && tod_r.min != $past(tod_r.min))
		else $error("seconds wrap did not carry");
	chk_min_wrap: assert property (@(posedge clock) disable iff (!rst_n)
		sec_c && tod_r.min == 8'h59 && quiet
		|=> tod_r.min == 8'h00 && tod_r.hour != $past(tod_r.hour))
		else $error("minutes wrap did not carry");
	chk_hour_pm: assert property (@(posedge clock) disable iff (!rst_n)
		min_c && !hour_mode_24 && tod_r.hour == 8'h23 && quiet
		|=> tod_r.hour == 8'h24 && tod_r.mday == $past(tod_r.mday))
		else $error("pm hour step wrong");
	chk_hour_12: assert property (@(posedge clock) disable iff (!rst_n)
		min_c && !hour_mode_24 && tod_r.hour == 8'h31 && quiet
		|=> tod_r.hour == 8'h12 && tod_r.mday != $past(tod_r.mday))
		else $error("PM11 rollover wrong");
	chk_feb_len: assert property (@(posedge clock) disable iff (!rst_n)
		day_c && tod_r.mon[4:0] == 5'h02 && tod_r.mday == 8'h28 &&
		tod_r.year == 8'h03 && quiet
		|=> tod_r.mday == 8'h01 && tod_r.mon[4:0] == 5'h03)
		else $error("february length wrong");
	chk_wday_mod: assert property (@(posedge clock) disable iff (!rst_n)
		day_c && tod_r.wday == 8'h06 && quiet |=> tod_r.wday == 8'h00)
		else $error("weekday did not wrap");
	chk_century: assert property (@(posedge clock) disable iff (!rst_n)
		cen_c && quiet |=> tod_r.year == 8'h00 &&
		tod_r.mon[CENTURY_BIT] != $past(tod_r.mon[CENTURY_BIT]))
		else $error("century bit did not toggle");
	chk_pirq_set: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && periodic_level_mode && !power_on_flag
		|=> pirq_r ##1 !interrupt_out_n)
		else $error("periodic flag or pin missing");
	chk_pirq_clr: assert property (@(posedge clock) disable iff (!rst_n)
		wr_flag && periodic_level_mode && !reg_wdata[PIRQ_BIT] &&
		!sec_tick |=> !pirq_r)
		else $error("periodic flag not cleared");
	chk_alarm_mask: assert property (@(posedge clock) disable iff (!rst_n)
		!weekly_alarm_enable |=> !walm_r)
		else $error("disabled alarm flag set");
	chk_alarm_time: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(walm_r) |-> $past(osc_edge) && $past(wcnt_r) == 2'h1)
		else $error("alarm flag set at wrong time");
	chk_alarm_clr: assert property (@(posedge clock) disable iff (!rst_n)
		walm_r && wr_flag && !reg_wdata[WALM_BIT] &&
		!(osc_edge && wcnt_r == 2'h1) |=> !walm_r)
		else $error("alarm flag not cleared");
	chk_pin_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!pirq_r && !walm_r && !dalm_r |=> interrupt_out_n)
		else $error("pin low with no flag");

	cov_sec_wrap: cover property (@(posedge clock) disable iff (!rst_n)
		sec_c);
	cov_year_wrap: cover property (@(posedge clock) disable iff (!rst_n)
		cen_c);
	cov_alarm: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(walm_r));
	cov_pirq_clr: cover property (@(posedge clock) disable iff (!rst_n)
		pirq_r ##1 !pirq_r);
endmodule

// File: rtc_pkg.sv
package rtc_pkg;

	// ****************************************
	// register offsets on the host port
	// ****************************************
	localparam logic [3:0] SEC_ADDR  = 4'h0;
	localparam logic [3:0] MIN_ADDR  = 4'h1;
	localparam logic [3:0] HOUR_ADDR = 4'h2;
	localparam logic [3:0] WDAY_ADDR = 4'h3;
	localparam logic [3:0] MDAY_ADDR = 4'h4;
	localparam logic [3:0] MON_ADDR  = 4'h5;
	localparam logic [3:0] YEAR_ADDR = 4'h6;
	localparam logic [3:0] FLAG_ADDR = 4'hF;

	// ****************************************
	// field positions and write masks
	// ****************************************
	localparam int         PIRQ_BIT    = 2;
	localparam int         WALM_BIT    = 1;
	localparam int         DALM_BIT    = 0;
	localparam int         CENTURY_BIT = 7;
	localparam int         PM_BIT      = 5;
	localparam logic [7:0] SEC_MASK    = 8'h7F;
	localparam logic [7:0] MIN_MASK    = 8'h7F;
	localparam logic [7:0] HOUR_MASK   = 8'h3F;
	localparam logic [7:0] WDAY_MASK   = 8'h07;
	localparam logic [7:0] MDAY_MASK   = 8'h3F;
	localparam logic [7:0] MON_MASK    = 8'h9F;
	localparam logic [7:0] YEAR_MASK   = 8'hFF;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] ONE_RST  = 8'h01;

	// ****************************************
	// timing
	// ****************************************
	localparam int OSC_HZ         = 32768;
	localparam int ALARM_DELAY_US = 61;
	// least time, rounded up to whole oscillator edges
	localparam int ALARM_DELAY_EDGES =
		(ALARM_DELAY_US * OSC_HZ + 999999) / 1000000;

	// ****************************************
	// time of day carrier
	// ****************************************
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] mday;
		logic [7:0] mon;
		logic [7:0] year;
	} tod_t;

endpackage

// File: sec_divider.sv
`timescale 1ns/10ps
module sec_divider
	import rtc_pkg::*;
#(
	parameter int EDGES_PER_SEC = OSC_HZ
)
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic osc_edge,
	input  wire logic clear,
	output logic      sec_tick
);
	logic [15:0] cnt_r;
	localparam logic [15:0] LAST = 16'(EDGES_PER_SEC - 1);

	// sub-second stages; a clear restarts a full second
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r    <= 16'h0000;
			sec_tick <= 1'b0;
		end
		else
		begin
			sec_tick <= 1'b0;
			if (clear)
				cnt_r <= 16'h0000;
			else if (osc_edge)
			begin
				if (cnt_r == LAST)
				begin
					cnt_r    <= 16'h0000;
					sec_tick <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	chk_div_clear: assert property (@(posedge clock)
		disable iff (!rst_n)
		clear |=> cnt_r == 16'h0000 && !sec_tick)
		else $error("divider not cleared by seconds write");
endmodule
